// file: hw/mpc_pkg.sv
// package of constants for the memory range protection checker
// ===========================================================================
package mpc_pkg;
   localparam int NUM_SETS   = 2;
   localparam int NUM_DRANGE = 4;
   localparam int NUM_CRANGE = 2;
   // ========================================================================
   // register map (word addresses are byte offsets)
   localparam logic [11:0] DATA_LOW_BASE  = 12'h000; // set*0x40 + n*4
   localparam logic [11:0] DATA_HIGH_BASE = 12'h010;
   localparam logic [11:0] DATA_MODE_OFF  = 12'h020;
   localparam logic [11:0] CODE_LOW_BASE  = 12'h024; // set*0x40 + n*4
   localparam logic [11:0] CODE_HIGH_BASE = 12'h02c;
   localparam logic [11:0] CODE_MODE_OFF  = 12'h034;
   localparam logic [11:0] SET_STRIDE     = 12'h040;
   localparam logic [11:0] CTRL_OFF       = 12'h080;
   localparam logic [11:0] STATUS_OFF     = 12'h084;
   // ========================================================================
   // field positions
   localparam int MODE_BYTE = 8;
   localparam int XBU = 0;  // fetch_top_match_trace_flag
   localparam int XBL = 3;  // fetch_bottom_match_trace_flag
   localparam int XS  = 5;  // fetch_in_range_trace_flag
   localparam int XE  = 7;  // fetch_permit_bit
   localparam int DRBU = 0;
   localparam int DWBU = 1;
   localparam int DRBL = 2;
   localparam int DWBL = 3;
   localparam int DRS  = 4;
   localparam int DWS  = 5;
   localparam int DRE  = 6;
   localparam int DWE  = 7;
   localparam logic [31:0] CODE_MODE_MASK = 32'h0000_a9a9;
   localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
   localparam logic        CTRL_PROT_EN_RST = 1'b0;
endpackage : mpc_pkg

// file: hw/mpc_range_cmp.sv
// one range comparator: in-range and bound equality
`timescale 1ns/10ps
module mpc_range_cmp (
   input  wire logic [31:0] addr,     // first byte address
   input  wire logic [31:0] lowLim,   // lower bound
   input  wire logic [31:0] highLim,  // upper bound
   output logic             inRange,  // lower <= addr < upper
   output logic             atLow,    // addr equals lower bound
   output logic             atHigh    // addr equals upper bound
);
   assign inRange = (addr >= lowLim) && (addr < highLim);
   assign atLow   = (addr == lowLim);
   assign atHigh  = (addr == highLim);
endmodule : mpc_range_cmp

// file: hw/mpc_table_check.sv
// checks one address against a table of ranges with byte mode fields
`timescale 1ns/10ps
module mpc_table_check #(
   parameter int N = 2
) (
   input  wire logic [31:0]    addr,      // address under check
   input  wire logic [N*32-1:0] lowLims,  // lower bounds, range 0 low
   input  wire logic [N*32-1:0] highLims, // upper bounds
   input  wire logic [N-1:0]   permitEn,  // permit bit per range
   input  wire logic [N-1:0]   inTrace,   // in-range trace per range
   input  wire logic [N-1:0]   lowTrace,  // lower-bound trace per range
   input  wire logic [N-1:0]   highTrace, // upper-bound trace per range
   output logic                permit,    // some matching range permits
   output logic [N-1:0]        dbgHit     // debug signal per range
);
   logic [N-1:0] inR;
   logic [N-1:0] atL;
   logic [N-1:0] atH;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_rng
         mpc_range_cmp u_cmp (
            .addr    (addr),
            .lowLim  (lowLims[i*32 +: 32]),
            .highLim (highLims[i*32 +: 32]),
            .inRange (inR[i]),
            .atLow   (atL[i]),
            .atHigh  (atH[i])
         );
         assign dbgHit[i] = (inTrace[i] & inR[i]) | (lowTrace[i] & atL[i])
                          | (highTrace[i] & atH[i]);
      end
   endgenerate
   assign permit = |(inR & permitEn);
endmodule : mpc_table_check

// file: hw/mpc_checker.sv
// top level: register sets on APB and same-cycle access checking
`timescale 1ns/10ps
module mpc_checker
   import mpc_pkg::*;
(
   input  wire logic        mclk,        // core clock
   input  wire logic        rst_n,       // sync reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [11:0] paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic [31:0]      prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error
   input  wire logic [1:0]  activeSetSelect, // set-select from status word
   input  wire logic        dataReq,     // load/store request
   input  wire logic        dataWrite,   // 1 store, 0 load
   input  wire logic [31:0] dataAddr,    // first byte address
   input  wire logic        fetchReq,    // instruction fetch request
   input  wire logic [31:0] fetchPc,     // fetch program counter
   output logic             dataTrap,    // data protection trap
   output logic             fetchTrap,   // code protection trap
   output logic [3:0]       dataDebug,   // per data range debug signal
   output logic [1:0]       fetchDebug   // per code range debug signal
);
   import mpc_pkg::*;

   // ========================================================================
   // register storage
   logic [31:0] dLow  [NUM_SETS][NUM_DRANGE];
   logic [31:0] dHigh [NUM_SETS][NUM_DRANGE];
   logic [31:0] dMode [NUM_SETS];
   logic [31:0] cLow  [NUM_SETS][NUM_CRANGE];
   logic [31:0] cHigh [NUM_SETS][NUM_CRANGE];
   logic [31:0] cMode [NUM_SETS];
   logic        protEn;
   logic        lastDataTrap;
   logic        lastFetchTrap;

   // ========================================================================
   // APB decode
   wire         setSel   = paddr[6];
   wire  [5:0]  inSet    = paddr[5:0];
   wire         inTable  = (paddr[11:7] == 5'h00);
   wire         wrStrobe = psel & penable & pwrite;
   wire         isDLow   = inTable && ({6'h0, inSet} < DATA_HIGH_BASE);
   wire         isDHigh  = inTable && ({6'h0, inSet} >= DATA_HIGH_BASE)
                           && ({6'h0, inSet} < DATA_MODE_OFF);
   wire         isDMode  = inTable && ({6'h0, inSet} == DATA_MODE_OFF);
   wire         isCLow   = inTable && ({6'h0, inSet} >= CODE_LOW_BASE)
                           && ({6'h0, inSet} < CODE_HIGH_BASE);
   wire         isCHigh  = inTable && ({6'h0, inSet} >= CODE_HIGH_BASE)
                           && ({6'h0, inSet} < CODE_MODE_OFF);
   wire         isCMode  = inTable && ({6'h0, inSet} == CODE_MODE_OFF);
   wire         isCtrl   = (paddr == CTRL_OFF);
   wire         isStat   = (paddr == STATUS_OFF);
   wire         aligned  = (paddr[1:0] == 2'b00);
   wire         mapped   = aligned & (isDLow | isDHigh | isDMode | isCLow
                           | isCHigh | isCMode | isCtrl | isStat);
   wire  [1:0]  dIdx     = inSet[3:2];
   wire  [5:0]  cOffL    = inSet - CODE_LOW_BASE[5:0];
   wire  [5:0]  cOffH    = inSet - CODE_HIGH_BASE[5:0];
   wire         cIdxL    = cOffL[2];
   wire         cIdxH    = cOffH[2];

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // ========================================================================
   // register writes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         for (int s = 0; s < NUM_SETS; s++) begin
            dMode[s] <= RESET_WORD;
            cMode[s] <= RESET_WORD;
            for (int n = 0; n < NUM_DRANGE; n++) begin
               dLow[s][n]  <= RESET_WORD;
               dHigh[s][n] <= RESET_WORD;
            end
            for (int n = 0; n < NUM_CRANGE; n++) begin
               cLow[s][n]  <= RESET_WORD;
               cHigh[s][n] <= RESET_WORD;
            end
         end
         protEn <= CTRL_PROT_EN_RST;
      end else if (wrStrobe && mapped) begin
         if (isDLow)  dLow[setSel][dIdx]  <= pwdata;
         if (isDHigh) dHigh[setSel][dIdx] <= pwdata;
         if (isDMode) dMode[setSel]       <= pwdata;
         if (isCLow)  cLow[setSel][cIdxL] <= pwdata;
         if (isCHigh) cHigh[setSel][cIdxH] <= pwdata;
         if (isCMode) cMode[setSel] <= pwdata & CODE_MODE_MASK;
         if (isCtrl)  protEn <= pwdata[0];
      end
   end

   // ========================================================================
   // register reads
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata <= RESET_WORD;
      end else if (psel && !penable && !pwrite) begin
         prdata <= RESET_WORD;
         if (isDLow)  prdata <= dLow[setSel][dIdx];
         if (isDHigh) prdata <= dHigh[setSel][dIdx];
         if (isDMode) prdata <= dMode[setSel];
         if (isCLow)  prdata <= cLow[setSel][cIdxL];
         if (isCHigh) prdata <= cHigh[setSel][cIdxH];
         if (isCMode) prdata <= cMode[setSel];
         if (isCtrl)  prdata <= {31'h0, protEn};
         if (isStat)  prdata <= {28'h0, lastFetchTrap, lastDataTrap,
                                 1'b0, activeSetSelect[0]};
         if (!mapped) prdata <= RESET_WORD;
      end
   end

   // ========================================================================
   // active set selection
   wire         act = activeSetSelect[0];
   logic [NUM_DRANGE*32-1:0] dLowV;
   logic [NUM_DRANGE*32-1:0] dHighV;
   logic [NUM_CRANGE*32-1:0] cLowV;
   logic [NUM_CRANGE*32-1:0] cHighV;
   logic [NUM_DRANGE-1:0]    dPerm;
   logic [NUM_DRANGE-1:0]    dInT;
   logic [NUM_DRANGE-1:0]    dLoT;
   logic [NUM_DRANGE-1:0]    dHiT;
   logic [NUM_CRANGE-1:0]    cPerm;
   logic [NUM_CRANGE-1:0]    cInT;
   logic [NUM_CRANGE-1:0]    cLoT;
   logic [NUM_CRANGE-1:0]    cHiT;

   genvar g;
   generate
      for (g = 0; g < NUM_DRANGE; g++) begin : g_d
         assign dLowV[g*32 +: 32]  = dLow[act][g];
         assign dHighV[g*32 +: 32] = dHigh[act][g];
         // data mode byte: permit and trace by access direction
         assign dPerm[g] = dMode[act][g*MODE_BYTE + (dataWrite ? DWE : DRE)];
         assign dInT[g]  = dMode[act][g*MODE_BYTE + (dataWrite ? DWS : DRS)];
         assign dLoT[g]  = dMode[act][g*MODE_BYTE
                                      + (dataWrite ? DWBL : DRBL)];
         assign dHiT[g]  = dMode[act][g*MODE_BYTE
                                      + (dataWrite ? DWBU : DRBU)];
      end
      for (g = 0; g < NUM_CRANGE; g++) begin : g_c
         assign cLowV[g*32 +: 32]  = cLow[act][g];
         assign cHighV[g*32 +: 32] = cHigh[act][g];
         assign cPerm[g] = cMode[act][g*MODE_BYTE + XE];
         assign cInT[g]  = cMode[act][g*MODE_BYTE + XS];
         assign cLoT[g]  = cMode[act][g*MODE_BYTE + XBL];
         assign cHiT[g]  = cMode[act][g*MODE_BYTE + XBU];
      end
   endgenerate

   // ========================================================================
   // table checks, combinational so results are same-cycle
   logic                  dPermit;
   logic                  cPermit;
   logic [NUM_DRANGE-1:0] dHit;
   logic [NUM_CRANGE-1:0] cHit;

   mpc_table_check #(.N(NUM_DRANGE)) u_data (
      .addr      (dataAddr),
      .lowLims   (dLowV),
      .highLims  (dHighV),
      .permitEn  (dPerm),
      .inTrace   (dInT),
      .lowTrace  (dLoT),
      .highTrace (dHiT),
      .permit    (dPermit),
      .dbgHit    (dHit)
   );

   mpc_table_check #(.N(NUM_CRANGE)) u_code (
      .addr      (fetchPc),
      .lowLims   (cLowV),
      .highLims  (cHighV),
      .permitEn  (cPerm),
      .inTrace   (cInT),
      .lowTrace  (cLoT),
      .highTrace (cHiT),
      .permit    (cPermit),
      .dbgHit    (cHit)
   );

   // no privilege input: every level is checked the same way
   assign dataTrap   = dataReq & protEn & ~dPermit;
   assign fetchTrap  = fetchReq & protEn & ~cPermit;
   assign dataDebug  = dataReq ? dHit : '0;
   assign fetchDebug = fetchReq ? cHit : '0;

   // ========================================================================
   // sticky-free status: last trap outcome of each path
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lastDataTrap  <= 1'b0;
         lastFetchTrap <= 1'b0;
      end else begin
         if (dataReq)  lastDataTrap  <= dataTrap;
         if (fetchReq) lastFetchTrap <= fetchTrap;
      end
   end
endmodule : mpc_checker

// file: sim/mpc_checker_monitor.sv
// port assertions for the memory range protection checker
`timescale 1ns/10ps
module mpc_checker_monitor
   import mpc_pkg::*;
(
   input wire logic        mclk,            // core clock
   input wire logic        rst_n,           // sync reset, active low
   input wire logic        psel,            // APB select
   input wire logic        penable,         // APB enable
   input wire logic        pwrite,          // APB direction
   input wire logic [11:0] paddr,           // APB byte address
   input wire logic [31:0] prdata,          // APB read data
   input wire logic        pready,          // APB ready
   input wire logic        pslverr,         // APB error
   input wire logic [1:0]  activeSetSelect, // set-select field
   input wire logic        fetchReq,        // fetch present
   input wire logic [31:0] fetchPc,         // fetch address
   input wire logic        dataReq,         // load/store present
   input wire logic        fetchTrap,       // code trap
   input wire logic        dataTrap,        // data trap
   input wire logic [3:0]  dataDebug,       // data debug hits
   input wire logic [1:0]  fetchDebug       // code debug hits
);
   // =====================================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence apbSetup; psel && !penable; endsequence
   sequence apbAccess; psel && penable; endsequence
   ready_in_access_a: assert property (apbSetup ##1 apbAccess |-> pready)
      else $error("access phase without ready");
   slverr_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   err_rdata_zero_a: assert property (apbAccess and !pwrite && pslverr
      |-> prdata == 32'h0) else $error("refused read returned data");
   misalign_err_a: assert property (apbAccess and paddr[1:0] != 2'b00
      |-> pslverr) else $error("misaligned access not refused");
   code_rsvd_zero_a: assert property (apbAccess and !pwrite &&
      (paddr == CODE_MODE_OFF || paddr == CODE_MODE_OFF + SET_STRIDE) |->
      (prdata & ~CODE_MODE_MASK) == 32'h0) else $error("reserved bits set");
   rdata_hold_a: assert property ($past(rst_n) && !$past(psel && !penable)
      |-> $stable(prdata)) else $error("read data moved");
   fetch_gated_a: assert property (!fetchReq |-> !fetchTrap &&
      fetchDebug == 2'b00) else $error("fetch result without fetch");
   data_gated_a: assert property (!dataReq |-> !dataTrap &&
      dataDebug == 4'h0) else $error("data result without access");
   fetch_stable_a: assert property (fetchReq && $past(fetchReq) &&
      $past(rst_n) && $stable(fetchPc) && $stable(activeSetSelect) &&
      !$past(psel && penable && pwrite) |-> $stable(fetchDebug) &&
      $stable(fetchTrap)) else $error("fetch result changed without cause");
endmodule : mpc_checker_monitor

bind mpc_checker mpc_checker_monitor mpc_checker_monitor_inst (.mclk, .rst_n,
   .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
   .activeSetSelect, .fetchReq, .fetchPc, .dataReq, .fetchTrap, .dataTrap,
   .dataDebug, .fetchDebug);

// file: sim/mpc_core_model.sv
// core-side model presenting load/store and fetch requests
`timescale 1ns/10ps
module mpc_core_model (
   input  wire logic        mclk,      // core clock
   input  wire logic [1:0]  cmdKind,   // 0 idle, 1 fetch, 2 load/store
   input  wire logic        cmdWrite,  // store when set
   input  wire logic [31:0] cmdAddr,   // first byte address
   output logic             dataReq,   // load/store present
   output logic             dataWrite, // store flag
   output logic [31:0]      dataAddr,  // data address
   output logic             fetchReq,  // fetch present
   output logic [31:0]      fetchPc    // fetch address
);
   initial {dataReq, dataWrite, dataAddr, fetchReq, fetchPc} = '0;
   // idle lines toggle so a stale address never looks valid
   always @(posedge mclk) begin
      fetchReq  <= cmdKind == 2'd1;
      dataReq   <= cmdKind == 2'd2;
      dataWrite <= cmdKind == 2'd2 ? cmdWrite : ~dataWrite;
      fetchPc   <= cmdKind == 2'd1 ? cmdAddr : ~fetchPc;
      dataAddr  <= cmdKind == 2'd2 ? cmdAddr : ~dataAddr;
   end
endmodule : mpc_core_model

// file: sim/tb_memory_range_protection_checker.sv
// self-checking bench for the memory range protection checker
`timescale 1ns/10ps
module tb_memory_range_protection_checker;
   import mpc_pkg::*;
   logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, cmdWrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, cmdAddr = 32'h0, prdata, rd;
   logic [1:0]  activeSetSelect = 2'b00, cmdKind = 2'd0, fetchDebug;
   logic        pready, pslverr, dataReq, dataWrite, fetchReq;
   logic        dataTrap, fetchTrap;
   logic [31:0] dataAddr, fetchPc;
   logic [3:0]  dataDebug;
   int          num_errors = 0, total_checks = 0, cycles = 0;
   mpc_checker mpc_checker_inst (.mclk, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .activeSetSelect, .dataReq,
      .dataWrite, .dataAddr, .fetchReq, .fetchPc, .dataTrap, .fetchTrap,
      .dataDebug, .fetchDebug);
   mpc_core_model mpc_core_model_inst (.mclk, .cmdKind, .cmdWrite, .cmdAddr,
      .dataReq, .dataWrite, .dataAddr, .fetchReq, .fetchPc);
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end
   // =====================================================================
   // tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // hold the request until ready is seen high; the cycle limit ends a hang
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   // exp is {trap, debug hits}; checked two and a half cycles after the command is set, and the command stays applied after the check
   task acc(input logic [1:0] k, input logic w, input logic [31:0] a,
            input logic [4:0] exp);
      @(posedge mclk);
      cmdKind  <= k;
      cmdWrite <= w;
      cmdAddr  <= a;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      check(k == 2'd1 ? {27'h0, fetchTrap, 2'b00, fetchDebug} :
            {27'h0, dataTrap, dataDebug}, {27'h0, exp});
   endtask : acc
   task give_verdict;
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict
   // =====================================================================
   // tests
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      rdchk(CODE_HIGH_BASE, 32'h0);
      rdchk(CODE_MODE_OFF + SET_STRIDE, 32'h0);
      wr(CODE_LOW_BASE + 12'h004, 32'hdead_beef);
      rdchk(CODE_LOW_BASE + 12'h004, 32'hdead_beef);
      wr(CODE_HIGH_BASE + SET_STRIDE, 32'hffff_fffc);
      rdchk(CODE_HIGH_BASE + SET_STRIDE, 32'hffff_fffc);
      wr(CODE_MODE_OFF, 32'hffff_ffff);
      rdchk(CODE_MODE_OFF, 32'h0000_a9a9);
      apb(1'b0, 12'h0fc, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b0, CODE_MODE_OFF + 12'h002, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      wr(CODE_LOW_BASE, 32'h0000_1000);
      wr(CODE_HIGH_BASE, 32'h0000_2000);
      wr(CODE_LOW_BASE + 12'h004, 32'h0000_1800);
      wr(CODE_HIGH_BASE + 12'h004, 32'h0000_3000);
      wr(CODE_MODE_OFF, 32'h0000_80a9);
      acc(2'd1, 1'b0, 32'h0000_0fff, 5'h00);
      wr(CTRL_OFF, 32'h0000_0001);
      acc(2'd1, 1'b0, 32'h0000_0fff, 5'h10);
      acc(2'd1, 1'b0, 32'h0000_1000, 5'h01);
      acc(2'd1, 1'b0, 32'h0000_1ffc, 5'h01);
      acc(2'd1, 1'b0, 32'h0000_2000, 5'h01);
      acc(2'd1, 1'b0, 32'h0000_3000, 5'h10);
      wr(CODE_MODE_OFF, 32'h0000_8080);
      acc(2'd1, 1'b0, 32'h0000_1000, 5'h00);
      wr(CODE_MODE_OFF, 32'h0000_0029);
      acc(2'd1, 1'b0, 32'h0000_1800, 5'h11);
      wr(CODE_MODE_OFF, 32'h0000_2900);
      acc(2'd1, 1'b0, 32'h0000_1800, 5'h12);
      @(posedge mclk) activeSetSelect <= 2'b01;
      acc(2'd1, 1'b0, 32'h0000_1000, 5'h10);
      wr(CODE_MODE_OFF + SET_STRIDE, 32'h0000_0080);
      acc(2'd1, 1'b0, 32'h0000_1000, 5'h00);
      wr(DATA_LOW_BASE, 32'h0000_0100);
      wr(DATA_HIGH_BASE, 32'h0000_0200);
      wr(DATA_MODE_OFF, 32'h0000_0050);
      activeSetSelect <= 2'b00;
      acc(2'd2, 1'b0, 32'h0000_0100, 5'h01);
      acc(2'd2, 1'b1, 32'h0000_0100, 5'h10);
      acc(2'd2, 1'b0, 32'h0000_0200, 5'h10);
      wr(DATA_LOW_BASE + 12'h004, 32'h0000_0180);
      wr(DATA_HIGH_BASE + 12'h004, 32'h0000_0300);
      wr(DATA_MODE_OFF, 32'h0000_8050);
      acc(2'd2, 1'b1, 32'h0000_01c0, 5'h00);
      acc(2'd2, 1'b0, 32'h0000_0250, 5'h10);
      wr(DATA_LOW_BASE + 12'h00c, 32'h0000_0400);
      wr(DATA_HIGH_BASE + 12'h00c, 32'h0000_0500);
      wr(DATA_MODE_OFF, 32'h0a00_8050);
      rdchk(DATA_MODE_OFF, 32'h0a00_8050);
      acc(2'd2, 1'b1, 32'h0000_0400, 5'h18);
      acc(2'd2, 1'b1, 32'h0000_0500, 5'h18);
      acc(2'd2, 1'b0, 32'h0000_0500, 5'h10);
      acc(2'd1, 1'b0, 32'h0000_1800, 5'h12);
      rdchk(CTRL_OFF, 32'h0000_0001);
      rdchk(STATUS_OFF, 32'h0000_000c);
      give_verdict();
   end
endmodule : tb_memory_range_protection_checker
